// ---- hdl/spi_fram_pkg.sv ----
// Shared constants and types for the serial nonvolatile memory command front end
package spi_fram_pkg;
   localparam int ADDR_W = 15;
   localparam int ADDR_HI_W = 7;
   localparam int BYTE_W = 8;
   localparam int BUF_W = ADDR_W + BYTE_W;

   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_RESET = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_MEM_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;
   localparam logic [7:0] OP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_IDENTITY_READ = 8'h9f;

   localparam int ST_WEL_BIT = 1;
   localparam int ST_BP0_BIT = 2;
   localparam int ST_BP1_BIT = 3;
   localparam int ST_WPEN_BIT = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
   localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

   localparam int PIN_W = 4;
   localparam int PIN_CS = 3;
   localparam int PIN_SCK = 2;
   localparam int PIN_SI = 1;
   localparam int PIN_WP = 0;
   localparam logic [3:0] PIN_RESET = 4'hf;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   localparam int CLK_PERIOD_NS = 10;
   localparam int SCK_PERIOD_NS = 160;
   localparam logic [3:0] SCK_HALF_CYCLES = 4'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));

   typedef enum logic [2:0] {
      D_IDLE, D_OPCODE, D_ADDR, D_DUMMY, D_WDATA, D_SWRITE, D_OUT, D_IGNORE
   } dev_state_t;

   typedef enum logic [2:0] {
      M_IDLE, M_LEAD, M_PRE, M_LOW, M_HIGH, M_TRAIL, M_GAP
   } mst_state_t;
endpackage

// ---- hdl/spi_fram_if.sv ----
// Four-wire serial link between the bus master and the memory front end
`timescale 1ns/1ps
interface spi_fram_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;

   modport master (output cs_n, output sck, output si, input so);
   modport device (input cs_n, input sck, input si, output so, output so_oe);
endinterface

// ---- hdl/spi_fram_device.sv ----
// Memory-side serial command front end: mode detect, opcode decode, write enable latch
`timescale 1ns/1ps
module spi_fram_device #(
   parameter logic [7:0] ID_BYTE = 8'h3c // Arbitrary identity value
) (
   input wire logic clk,
   input wire logic arst_n,
   spi_fram_if.device spi,
   input wire logic wp_n,
   output logic [14:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [14:0] wr_addr,
   output logic [7:0] wr_data,
   output logic write_enable_flag
);
   logic [3:0] pin_m_q;
   logic [3:0] pin_s_q;
   logic cs_prev_q;
   logic sck_prev_q;
   logic sel;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic mode3_q;
   logic armed_q;
   logic take;
   logic byte_done;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] new_byte;
   spi_fram_pkg::dev_state_t state_q;
   logic [7:0] op_q;
   logic op_done_q;
   logic addr_hi_done_q;
   logic [14:0] addr_q;
   logic stop_q;
   logic wel_q;
   logic wpen_q;
   logic [1:0] bp_q;
   logic [7:0] status_byte;
   logic write_ok;
   logic push;
   logic ld_q;
   logic [7:0] tx_q;
   logic so_q;
   logic so_oe_q;
   logic [22:0] buf_q [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic pop;

   function automatic spi_fram_pkg::dev_state_t decode_op(input logic [7:0] op);
      case (op)
         spi_fram_pkg::OP_LATCH_SET, spi_fram_pkg::OP_LATCH_RESET,
         spi_fram_pkg::OP_SLEEP: decode_op = spi_fram_pkg::D_IGNORE;
         spi_fram_pkg::OP_STATUS_READ, spi_fram_pkg::OP_IDENTITY_READ: decode_op = spi_fram_pkg::D_OUT;
         spi_fram_pkg::OP_STATUS_WRITE: decode_op = spi_fram_pkg::D_SWRITE;
         spi_fram_pkg::OP_MEM_READ, spi_fram_pkg::OP_FAST_READ,
         spi_fram_pkg::OP_MEM_WRITE: decode_op = spi_fram_pkg::D_ADDR;
         default: decode_op = spi_fram_pkg::D_IGNORE;
      endcase
   endfunction

   function automatic logic is_protected(input logic [14:0] a, input logic [1:0] bp);
      case (bp)
         spi_fram_pkg::BP_NONE: is_protected = 1'b0;
         spi_fram_pkg::BP_QUARTER: is_protected = a >= spi_fram_pkg::PROT_QUARTER_BASE;
         spi_fram_pkg::BP_HALF: is_protected = a >= spi_fram_pkg::PROT_HALF_BASE;
         default: is_protected = 1'b1;
      endcase
   endfunction

   // Two-stage synchronisers for the select, clock and data-in link pins and the protect pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_m_q <= spi_fram_pkg::PIN_RESET;
         pin_s_q <= spi_fram_pkg::PIN_RESET;
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b1;
      end else begin
         pin_m_q <= {spi.cs_n, spi.sck, spi.si, wp_n};
         pin_s_q <= pin_m_q;
         cs_prev_q <= pin_s_q[spi_fram_pkg::PIN_CS];
         sck_prev_q <= pin_s_q[spi_fram_pkg::PIN_SCK];
      end
   end

   assign sel = !pin_s_q[spi_fram_pkg::PIN_CS];
   assign cs_fall = cs_prev_q && sel;
   assign cs_rise = !cs_prev_q && !sel;
   assign sck_rise = sel && !sck_prev_q && pin_s_q[spi_fram_pkg::PIN_SCK];
   assign sck_fall = sel && sck_prev_q && !pin_s_q[spi_fram_pkg::PIN_SCK];
   assign take = sck_rise && armed_q && !cs_fall;
   assign byte_done = take && (bit_q == spi_fram_pkg::BIT_LAST);
   assign new_byte = {shift_q[6:0], pin_s_q[spi_fram_pkg::PIN_SI]};

   // Mode is taken from the clock level as select falls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode3_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (cs_fall) begin
         mode3_q <= pin_s_q[spi_fram_pkg::PIN_SCK];
         armed_q <= !pin_s_q[spi_fram_pkg::PIN_SCK];
      end else if (!sel) begin
         armed_q <= 1'b0;
      end else if (sck_fall) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bit_q <= '0;
         shift_q <= '0;
      end else if (cs_fall) begin
         bit_q <= '0;
      end else if (take) begin
         bit_q <= bit_q + 3'h1;
         shift_q <= new_byte;
      end
   end

   // Command sequencing; one opcode per select period
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= spi_fram_pkg::D_IDLE;
         op_q <= '0;
         op_done_q <= 1'b0;
         addr_hi_done_q <= 1'b0;
      end else if (cs_fall) begin
         state_q <= spi_fram_pkg::D_OPCODE;
         op_done_q <= 1'b0;
         addr_hi_done_q <= 1'b0;
      end else if (!sel) begin
         state_q <= spi_fram_pkg::D_IDLE;
      end else if (byte_done) begin
         case (state_q)
            spi_fram_pkg::D_OPCODE: begin
               op_q <= new_byte;
               op_done_q <= 1'b1;
               state_q <= decode_op(new_byte);
            end
            spi_fram_pkg::D_ADDR: begin
               addr_hi_done_q <= 1'b1;
               if (addr_hi_done_q) begin
                  if (op_q == spi_fram_pkg::OP_FAST_READ) begin
                     state_q <= spi_fram_pkg::D_DUMMY;
                  end else if (op_q == spi_fram_pkg::OP_MEM_WRITE) begin
                     state_q <= spi_fram_pkg::D_WDATA;
                  end else begin
                     state_q <= spi_fram_pkg::D_OUT;
                  end
               end
            end
            spi_fram_pkg::D_DUMMY: state_q <= spi_fram_pkg::D_OUT;
            spi_fram_pkg::D_SWRITE: state_q <= spi_fram_pkg::D_IGNORE;
            default: state_q <= state_q;
         endcase
      end
   end

   assign write_ok = wel_q && !stop_q && !is_protected(addr_q, bp_q);
   assign push = byte_done && (state_q == spi_fram_pkg::D_WDATA) && write_ok;

   // Address capture and auto increment, wrapping at the top
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_q <= '0;
         stop_q <= 1'b0;
      end else if (cs_fall) begin
         stop_q <= 1'b0;
      end else if (byte_done) begin
         case (state_q)
            spi_fram_pkg::D_ADDR: begin
               if (!addr_hi_done_q) begin
                  addr_q[14:8] <= new_byte[spi_fram_pkg::ADDR_HI_W-1:0];
               end else begin
                  addr_q[7:0] <= new_byte;
               end
            end
            spi_fram_pkg::D_WDATA: begin
               if (write_ok) begin
                  addr_q <= addr_q + 15'h1;
               end else begin
                  stop_q <= 1'b1;
               end
            end
            spi_fram_pkg::D_OUT: begin
               if (op_q == spi_fram_pkg::OP_MEM_READ || op_q == spi_fram_pkg::OP_FAST_READ) begin
                  addr_q <= addr_q + 15'h1;
               end
            end
            default: addr_q <= addr_q;
         endcase
      end
   end

   // Status register and write enable latch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wel_q <= 1'b0;
         wpen_q <= 1'b0;
         bp_q <= spi_fram_pkg::BP_NONE;
      end else begin
         if (byte_done && state_q == spi_fram_pkg::D_SWRITE && wel_q
             && !(wpen_q && !pin_s_q[spi_fram_pkg::PIN_WP])) begin
            wpen_q <= new_byte[spi_fram_pkg::ST_WPEN_BIT];
            bp_q <= new_byte[spi_fram_pkg::ST_BP1_BIT:spi_fram_pkg::ST_BP0_BIT];
         end
         if (cs_rise && op_done_q) begin
            case (op_q)
               spi_fram_pkg::OP_LATCH_SET: wel_q <= 1'b1;
               spi_fram_pkg::OP_LATCH_RESET: wel_q <= 1'b0;
               spi_fram_pkg::OP_STATUS_WRITE, spi_fram_pkg::OP_MEM_WRITE: wel_q <= 1'b0;
               default: wel_q <= wel_q;
            endcase
         end
      end
   end

   always_comb begin
      status_byte = spi_fram_pkg::STATUS_RESET;
      status_byte[spi_fram_pkg::ST_WEL_BIT] = wel_q;
      status_byte[spi_fram_pkg::ST_BP0_BIT] = bp_q[0];
      status_byte[spi_fram_pkg::ST_BP1_BIT] = bp_q[1];
      status_byte[spi_fram_pkg::ST_WPEN_BIT] = wpen_q;
   end

   // Output byte is loaded the cycle after each completed byte that leaves the front end in D_OUT
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ld_q <= 1'b0;
         tx_q <= '0;
      end else begin
         ld_q <= byte_done;
         if (ld_q && state_q == spi_fram_pkg::D_OUT) begin
            if (op_q == spi_fram_pkg::OP_STATUS_READ) begin
               tx_q <= status_byte;
            end else if (op_q == spi_fram_pkg::OP_IDENTITY_READ) begin
               tx_q <= ID_BYTE;
            end else begin
               tx_q <= rd_data;
            end
         end
      end
   end

   // Serial output changes on falling edges, released when deselected or when not in D_OUT
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (!sel || state_q != spi_fram_pkg::D_OUT) begin
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (sck_fall) begin
         so_q <= tx_q[spi_fram_pkg::BIT_LAST - bit_q];
         so_oe_q <= 1'b1;
      end
   end

   // Two-entry buffer between the link and the memory write port
   assign pop = wr_valid && wr_ready;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_q[0] <= '0;
         buf_q[1] <= '0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         if (push && cnt_q != 2'h2) begin
            buf_q[wr_ptr_q] <= {addr_q, new_byte};
            wr_ptr_q <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         cnt_q <= cnt_q + {1'b0, push && cnt_q != 2'h2} - {1'b0, pop};
      end
   end

   assign wr_valid = cnt_q != 2'h0;
   assign wr_addr = buf_q[rd_ptr_q][22:8];
   assign wr_data = buf_q[rd_ptr_q][7:0];
   assign rd_addr = addr_q;
   assign write_enable_flag = wel_q;
   assign spi.so = so_q;
   assign spi.so_oe = so_oe_q;
endmodule

// ---- hdl/spi_fram_master.sv ----
// Bus-master end: drives select and serial clock, shifts bytes out and in
`timescale 1ns/1ps
module spi_fram_master (
   input wire logic clk,
   input wire logic arst_n,
   spi_fram_if.master spi,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_mode3,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic busy
);
   spi_fram_pkg::mst_state_t state_q;
   logic [3:0] cnt_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] rx_sh_q;
   logic last_q;
   logic mode3_q;
   logic cs_n_q;
   logic sck_q;
   logic si_q;
   logic so_m_q;
   logic so_s_q;
   logic half_done;
   logic byte_end;

   assign half_done = cnt_q == spi_fram_pkg::SCK_HALF_CYCLES - 4'h1;
   assign byte_end = bit_q == spi_fram_pkg::BYTE_BITS;
   assign tx_ready = (state_q == spi_fram_pkg::M_IDLE)
                     || (state_q == spi_fram_pkg::M_HIGH && half_done && byte_end && !last_q);

   // Clock divider; counts the half periods only, the serial clock itself is driven by the state machine
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (state_q == spi_fram_pkg::M_IDLE || half_done) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_m_q <= 1'b0;
         so_s_q <= 1'b0;
      end else begin
         so_m_q <= spi.so;
         so_s_q <= so_m_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= spi_fram_pkg::M_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         rx_sh_q <= '0;
         last_q <= 1'b0;
         mode3_q <= 1'b0;
         cs_n_q <= 1'b1;
         sck_q <= 1'b0;
         si_q <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= '0;
      end else begin
         rx_valid <= 1'b0;
         case (state_q)
            spi_fram_pkg::M_IDLE: begin
               if (tx_valid) begin
                  sh_q <= tx_data;
                  last_q <= tx_last;
                  mode3_q <= tx_mode3;
                  sck_q <= tx_mode3;
                  state_q <= spi_fram_pkg::M_LEAD;
               end
            end
            spi_fram_pkg::M_LEAD: begin
               if (half_done) begin
                  cs_n_q <= 1'b0;
                  state_q <= spi_fram_pkg::M_PRE;
               end
            end
            spi_fram_pkg::M_PRE: begin
               if (half_done) begin
                  sck_q <= 1'b0;
                  si_q <= sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
                  bit_q <= '0;
                  state_q <= spi_fram_pkg::M_LOW;
               end
            end
            spi_fram_pkg::M_LOW: begin
               if (half_done) begin
                  sck_q <= 1'b1;
                  rx_sh_q <= {rx_sh_q[6:0], so_s_q};
                  bit_q <= bit_q + 4'h1;
                  state_q <= spi_fram_pkg::M_HIGH;
                  if (bit_q == spi_fram_pkg::BYTE_BITS - 4'h1) begin
                     rx_valid <= 1'b1;
                     rx_data <= {rx_sh_q[6:0], so_s_q};
                  end
               end
            end
            spi_fram_pkg::M_HIGH: begin
               if (half_done) begin
                  if (!byte_end) begin
                     sck_q <= 1'b0;
                     si_q <= sh_q[7];
                     sh_q <= {sh_q[6:0], 1'b0};
                     state_q <= spi_fram_pkg::M_LOW;
                  end else if (last_q) begin
                     sck_q <= mode3_q;
                     state_q <= spi_fram_pkg::M_TRAIL;
                  end else if (tx_valid) begin
                     sck_q <= 1'b0;
                     si_q <= tx_data[7];
                     sh_q <= {tx_data[6:0], 1'b0};
                     last_q <= tx_last;
                     bit_q <= '0;
                     state_q <= spi_fram_pkg::M_LOW;
                  end
               end
            end
            spi_fram_pkg::M_TRAIL: begin
               if (half_done) begin
                  cs_n_q <= 1'b1;
                  state_q <= spi_fram_pkg::M_GAP;
               end
            end
            spi_fram_pkg::M_GAP: begin
               if (half_done) begin
                  state_q <= spi_fram_pkg::M_IDLE;
               end
            end
            default: state_q <= spi_fram_pkg::M_IDLE;
         endcase
      end
   end

   assign busy = state_q != spi_fram_pkg::M_IDLE;
   assign spi.cs_n = cs_n_q;
   assign spi.sck = sck_q;
   assign spi.si = si_q;
endmodule

// ---- verification/spi_fram_chk.sv ----
// Concurrent checks on the four-wire link between the two ends
`timescale 1ns/1ps
module spi_fram_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence sel_mode0_s;
      $fell(cs_n) && !sck;
   endsequence
   sequence sel_mode3_s;
      $fell(cs_n) && sck;
   endsequence
   sequence desel_s;
      $rose(cs_n);
   endsequence

   chk_mode0_lead: assert property (sel_mode0_s |-> (!sck) [*8])
      else $error("clock left its low idle level too early");
   chk_mode3_lead: assert property (sel_mode3_s |-> sck [*8])
      else $error("clock left its high idle level too early");
   chk_oe_release: assert property (desel_s |-> ##[1:5] !so_oe)
      else $error("output not released after deselect");
   chk_oe_idle: assert property (cs_n [*6] |-> !so_oe)
      else $error("output driven while deselected");
   chk_oe_selected: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n))
      else $error("output driven without selection");
   chk_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck) && !$past(sck, 2))
      else $error("output changed outside the low clock phase");
   chk_so_hold_high: assert property (so_oe && sck && $past(sck) |-> $stable(so))
      else $error("output moved while clock high");
   chk_si_setup_hold: assert property (!cs_n && $rose(sck) |-> $stable(si) ##1 $stable(si))
      else $error("input data moved around rising clock");
   chk_cs_gap: assert property (desel_s |-> cs_n [*8])
      else $error("select gap too short");
endmodule

// ---- verification/spi_fram_command_front_end_test.sv ----
// Self-checking bench: master end and memory end joined over the link
`timescale 1ns/1ps
module spi_fram_command_front_end_test;
   localparam logic [7:0] ID_EXP = 8'h3c; // Arbitrary identity value
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_last = 1'b0;
   logic tx_mode3 = 1'b0;
   logic wp_n = 1'b1;
   logic wr_ready = 1'b0;
   logic tx_ready, rx_valid, busy, wr_valid, write_enable_flag;
   logic [7:0] rx_data, wr_data, rd_data;
   logic [14:0] rd_addr, wr_addr;
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   logic oe_seen = 1'b0;
   int miscompares = 0;
   int cmp_count = 0;

   always #5 clk = ~clk;

   function automatic logic [7:0] mem_at(input logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]};
   endfunction
   assign rd_data = mem_at(rd_addr);

   spi_fram_if spi_fram_if_inst ();
   spi_fram_master spi_fram_master_inst (.clk(clk), .arst_n(arst_n), .spi(spi_fram_if_inst.master),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_mode3(tx_mode3),
      .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy));
   spi_fram_device #(.ID_BYTE(ID_EXP)) spi_fram_device_inst (.clk(clk), .arst_n(arst_n),
      .spi(spi_fram_if_inst.device), .wp_n(wp_n), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .write_enable_flag(write_enable_flag));
   spi_fram_chk spi_fram_chk_inst (.clk(clk), .arst_n(arst_n), .cs_n(spi_fram_if_inst.cs_n),
      .sck(spi_fram_if_inst.sck), .si(spi_fram_if_inst.si), .so(spi_fram_if_inst.so),
      .so_oe(spi_fram_if_inst.so_oe));

   always @(posedge clk) begin
      if (spi_fram_if_inst.so_oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait at falling edges for a level
   task automatic wait_level(ref logic sig, input logic lvl, input string name);
      int n;
      n = 0;
      while (sig !== lvl) begin
         @(negedge clk);
         n++;
         if (n > 400) begin
            miscompares++;
            $display("[FAIL] %s expected level seen timeout", name);
            print_verdict();
         end
      end
   endtask

   // One whole transaction from tx_q, bytes read back into rx_q
   task automatic xfer(input logic m3);
      oe_seen = 1'b0;
      rx_q = {};
      for (int i = 0; i < tx_q.size(); i++) begin
         @(negedge clk);
         tx_valid = 1'b1;
         tx_data = tx_q[i];
         tx_last = (i == tx_q.size() - 1);
         tx_mode3 = m3;
         wait_level(tx_ready, 1'b1, "tx_ready");
         @(negedge clk);
         tx_valid = 1'b0;
         wait_level(rx_valid, 1'b1, "rx_valid");
         rx_q.push_back(rx_data);
      end
      wait_level(busy, 1'b0, "busy");
      check("ready when idle", 1'b1, tx_ready);
      // Device needs a few clocks to see the select rise
      repeat (4) @(negedge clk);
   endtask

   task automatic cmd(input logic [7:0] op, input logic m3);
      tx_q = {op};
      xfer(m3);
   endtask

   task automatic status_is(input logic m3, input logic [7:0] exp, input string name);
      tx_q = {8'h05, 8'h00};
      xfer(m3);
      check(name, exp, rx_q[1]);
   endtask

   task automatic pop(input logic [14:0] a, input logic [7:0] d);
      wait_level(wr_valid, 1'b1, "wr_valid");
      check("write address", a, wr_addr);
      check("write data", d, wr_data);
      wr_ready = 1'b1;
      @(negedge clk);
      wr_ready = 1'b0;
   endtask

   task automatic scn_reset_state();
      check("flag after reset", 1'b0, write_enable_flag);
      status_is(1'b0, 8'h00, "status after reset");
   endtask

   task automatic scn_latch();
      cmd(8'h06, 1'b1);
      check("flag after set", 1'b1, write_enable_flag);
      status_is(1'b1, 8'h02, "status in mode 3");
      cmd(8'hb9, 1'b0);
      check("flag after sleep", 1'b1, write_enable_flag);
      cmd(8'h04, 1'b1);
      check("flag after latch reset", 1'b0, write_enable_flag);
   endtask

   task automatic scn_write();
      tx_q = {8'h02, 8'h00, 8'h20, 8'h11};
      xfer(1'b0);
      check("write with latch clear", 1'b0, wr_valid);
      cmd(8'h06, 1'b0);
      // Receiver stalls: two words kept, third dropped
      tx_q = {8'h02, 8'hff, 8'hff, 8'ha5, 8'h5a, 8'hc3};
      xfer(1'b0);
      check("flag after write", 1'b0, write_enable_flag);
      pop(15'h7fff, 8'ha5);
      pop(15'h0000, 8'h5a);
      check("buffer empty", 1'b0, wr_valid);
   endtask

   task automatic scn_read();
      tx_q = {8'h03, 8'h80, 8'h05, 8'h00, 8'h00};
      xfer(1'b0);
      check("read byte 0", mem_at(15'h0005), rx_q[3]);
      check("read byte 1", mem_at(15'h0006), rx_q[4]);
      tx_q = {8'h0b, 8'h7f, 8'hff, 8'h00, 8'h00, 8'h00};
      xfer(1'b1);
      check("fast read byte 0", mem_at(15'h7fff), rx_q[4]);
      check("fast read wrap", mem_at(15'h0000), rx_q[5]);
      tx_q = {8'h9f, 8'h00};
      xfer(1'b0);
      check("identity byte", ID_EXP, rx_q[1]);
   endtask

   task automatic scn_invalid();
      logic [7:0] ops[5] = '{8'hc3, 8'hc2, 8'h5a, 8'h5b, 8'hff};
      foreach (ops[i]) begin
         tx_q = {ops[i], 8'h06, 8'h06};
         xfer(i[0]);
         check("output enable on invalid", 1'b0, oe_seen);
         check("flag after invalid", 1'b0, write_enable_flag);
      end
   endtask

   task automatic scn_status_write();
      cmd(8'h06, 1'b0);
      tx_q = {8'h01, 8'h8e};
      xfer(1'b0);
      status_is(1'b0, 8'h8c, "status after write");
      wp_n = 1'b0;
      cmd(8'h06, 1'b1);
      tx_q = {8'h01, 8'h00};
      xfer(1'b1);
      status_is(1'b1, 8'h8c, "protected status write");
      wp_n = 1'b1;
      cmd(8'h06, 1'b0);
      tx_q = {8'h01, 8'h00};
      xfer(1'b0);
      status_is(1'b0, 8'h00, "status cleared");
   endtask

   initial begin
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      scn_reset_state();
      scn_latch();
      scn_write();
      scn_read();
      scn_invalid();
      scn_status_write();
      print_verdict();
   end
endmodule
